// >>> hdl/ipv_regs.svh
// register indices, field positions, write masks and fixed codes of the interrupt arbiter
`ifndef IPV_REGS_SVH
`define IPV_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define IPV_IDX_PRIO_A      32'hffff8348
`define IPV_IDX_PRIO_B      32'hffff834a
`define IPV_IDX_PRIO_C      32'hffff834c
`define IPV_IDX_PRIO_D      32'hffff834e
`define IPV_IDX_PRIO_E      32'hffff8350
`define IPV_IDX_PRIO_F      32'hffff8352
`define IPV_IDX_PRIO_G      32'hffff8354
`define IPV_IDX_PRIO_H      32'hffff8356
`define IPV_IDX_SENSE_CTRL  32'hffff8358
`define IPV_IDX_REQ_FLAGS   32'hffff835a

// ==========================================================
// writable bits; reserved bits are stored as zero
`define IPV_WMASK_PRIO_A    16'hffff
`define IPV_WMASK_PRIO_B    16'h00ff
`define IPV_WMASK_PRIO_C    16'h0000
`define IPV_WMASK_PRIO_D    16'hffff
`define IPV_WMASK_PRIO_E    16'hff00
`define IPV_WMASK_PRIO_F    16'h000f
`define IPV_WMASK_PRIO_G    16'hf0ff
`define IPV_WMASK_PRIO_H    16'hf000
`define IPV_WMASK_SENSE     8'hf3

// ==========================================================
// field positions and reset values
`define IPV_NMI_EDGE_BIT    8
`define IPV_NMI_LEVEL_BIT   15
`define IPV_PRIO_RESET      16'h0000
`define IPV_SENSE_RESET     8'h00

// ==========================================================
// fixed codes of the non-maskable input
`define IPV_NMI_VECTOR      8'h0b
`define IPV_NMI_MASK        4'hf

`endif

// >>> hdl/ipv_pkg.sv
// types shared by the interrupt arbiter and its bench
package ipv_pkg;

  typedef logic [7:0][15:0] ipv_prio_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ipv_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ipv_apb_rsp_type;

  typedef struct packed {
    logic       req;
    logic [3:0] level;
    logic [7:0] vector;
    logic [9:0] vec_offset;
    logic       mask_load;
    logic [3:0] new_mask;
  } ipv_cpu_int_type;

  typedef struct packed {
    ipv_prio_type    prio;
    logic [7:0]      sense;
    logic            nonmask_edge_select;
    logic [5:0]      ext_s1;
    logic [5:0]      ext_s2;
    logic [5:0]      ext_prev;
    logic [5:0]      edge_flag;
    logic [5:0]      armed;
    logic            nmi_s1;
    logic            nmi_s2;
    logic            nmi_prev;
    logic            nmi_pend;
    logic            win_nmi;
    logic [4:0]      win_idx;
    ipv_apb_rsp_type rsp;
    ipv_cpu_int_type cpu;
  } ipv_state_type;

endpackage

// >>> hdl/ipv_int_arbiter.sv
// external pin sensing, priority arbitration and vector output of the interrupt arbiter
//
// Contract
// R1 - each pin's sense select bit picks low-level or falling-edge sensing
// R2 - each external pin has its own 0..15 priority in registers A and B
// R3 - level mode: request is active exactly while the pin is low
// R4 - level mode: pin flag shows the current request level
// R5 - edge mode: a high-to-low change raises a request
// R6 - edge mode: request stays latched until accepted, visible in the flag
// R7 - software clears a latched flag only by reading 1 then writing 0
// R8 - accepting a pin interrupt loads the cpu mask with its priority
// R9 - every peripheral source has a distinct vector
// R10 - each peripheral module has a 0..15 priority in registers C to H; the code uses D to H only, C has no writable bits
// R11 - accepting a peripheral interrupt loads the cpu mask with its priority
// R12 - the accepted source selects the vector table entry fetched
// R13 - vector table offset is vector number times four
// R14 - nmi vector 11 priority 16; pins use vectors 64-67, 70, 71
// R15 - peripheral vectors 88..153 as fixed in the vector table
// R16 - sources sharing one field are ranked in fixed order
// R17 - every priority field is independently writable, four bits each
// R18 - reset sets every priority to level 0
// R19 - equal levels resolved by nmi first, then ascending vector number
// R20 - priority level 0 masks a source
// R21 - nmi is edge sensed, selectable polarity, always accepted, mask 15
// R22 - sense bit 0 means low level (reset value), 1 falling edge
// R23 - request to the cpu only above the current mask, nmi excepted
// R24 - pins are sampled on the clock; fall is previous high, current low
`timescale 1ns/10ps
`include "ipv_regs.svh"

module ipv_int_arbiter (
  input  wire logic                     REF_CLK,
  input  wire logic                     SRST,
  input  wire ipv_pkg::ipv_apb_req_type APB_REQ,
  output      ipv_pkg::ipv_apb_rsp_type APB_RSP,
  input  wire logic [5:0]               EXT_REQ_PIN,
  input  wire logic                     NMI_PIN,
  input  wire logic [19:0]              PERIPH_REQ,
  input  wire logic [3:0]               CPU_MASK,
  input  wire logic                     INT_ACK,
  output      ipv_pkg::ipv_cpu_int_type CPU_INT
);
  import ipv_pkg::*;

  // ==========================================================
  // helpers

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'b00};
  endfunction

  // register number 0..9, 4'hf for an unmapped address
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    case (a)
      byte_addr(`IPV_IDX_PRIO_A):     reg_sel = 4'h0;
      byte_addr(`IPV_IDX_PRIO_B):     reg_sel = 4'h1;
      byte_addr(`IPV_IDX_PRIO_C):     reg_sel = 4'h2;
      byte_addr(`IPV_IDX_PRIO_D):     reg_sel = 4'h3;
      byte_addr(`IPV_IDX_PRIO_E):     reg_sel = 4'h4;
      byte_addr(`IPV_IDX_PRIO_F):     reg_sel = 4'h5;
      byte_addr(`IPV_IDX_PRIO_G):     reg_sel = 4'h6;
      byte_addr(`IPV_IDX_PRIO_H):     reg_sel = 4'h7;
      byte_addr(`IPV_IDX_SENSE_CTRL): reg_sel = 4'h8;
      byte_addr(`IPV_IDX_REQ_FLAGS):  reg_sel = 4'h9;
      default:                        reg_sel = 4'hf;
    endcase
  endfunction

  function automatic logic [15:0] prio_wmask(input logic [2:0] r);
    case (r)
      3'h0:    prio_wmask = `IPV_WMASK_PRIO_A;
      3'h1:    prio_wmask = `IPV_WMASK_PRIO_B;
      3'h2:    prio_wmask = `IPV_WMASK_PRIO_C;
      3'h3:    prio_wmask = `IPV_WMASK_PRIO_D;
      3'h4:    prio_wmask = `IPV_WMASK_PRIO_E;
      3'h5:    prio_wmask = `IPV_WMASK_PRIO_F;
      3'h6:    prio_wmask = `IPV_WMASK_PRIO_G;
      default: prio_wmask = `IPV_WMASK_PRIO_H;
    endcase
  endfunction

  // sense and flag bit of external pin i (pins 0-3, 6, 7)
  function automatic logic [2:0] pin_bit(input int i);
    case (i)
      0:       pin_bit = 3'h7;
      1:       pin_bit = 3'h6;
      2:       pin_bit = 3'h5;
      3:       pin_bit = 3'h4;
      4:       pin_bit = 3'h1;
      default: pin_bit = 3'h0;
    endcase
  endfunction

  // R16 shared fields: sources sharing a nibble compete only by index
  // R17 field of source i: register number and nibble (3 = bits 15:12)
  function automatic logic [3:0] src_prio(input ipv_prio_type p, input logic [4:0] i);
    logic [2:0] r;
    logic [1:0] n;
    r = 3'h0;
    n = 2'h0;
    case (i)
      5'd0:                      begin r = 3'h0; n = 2'h3; end
      5'd1:                      begin r = 3'h0; n = 2'h2; end
      5'd2:                      begin r = 3'h0; n = 2'h1; end
      5'd3:                      begin r = 3'h0; n = 2'h0; end
      5'd4:                      begin r = 3'h1; n = 2'h1; end
      5'd5:                      begin r = 3'h1; n = 2'h0; end
      5'd6, 5'd7, 5'd8, 5'd9:    begin r = 3'h3; n = 2'h3; end
      5'd10:                     begin r = 3'h3; n = 2'h2; end
      5'd11, 5'd12:              begin r = 3'h3; n = 2'h1; end
      5'd13:                     begin r = 3'h3; n = 2'h0; end
      5'd14, 5'd15:              begin r = 3'h4; n = 2'h3; end
      5'd16:                     begin r = 3'h4; n = 2'h2; end
      5'd17, 5'd18, 5'd19, 5'd20: begin r = 3'h5; n = 2'h0; end
      5'd21:                     begin r = 3'h6; n = 2'h3; end
      5'd22:                     begin r = 3'h6; n = 2'h1; end
      5'd23:                     begin r = 3'h6; n = 2'h0; end
      default:                   begin r = 3'h7; n = 2'h3; end
    endcase
    src_prio = p[r][{n, 2'b00} +: 4];
  endfunction

  // R14 R15 vector numbers, ascending with source index
  function automatic logic [7:0] src_vector(input logic [4:0] i);
    case (i)
      5'd0:    src_vector = 8'h40;
      5'd1:    src_vector = 8'h41;
      5'd2:    src_vector = 8'h42;
      5'd3:    src_vector = 8'h43;
      5'd4:    src_vector = 8'h46;
      5'd5:    src_vector = 8'h47;
      5'd6:    src_vector = 8'h58;
      5'd7:    src_vector = 8'h59;
      5'd8:    src_vector = 8'h5a;
      5'd9:    src_vector = 8'h5b;
      5'd10:   src_vector = 8'h5c;
      5'd11:   src_vector = 8'h60;
      5'd12:   src_vector = 8'h61;
      5'd13:   src_vector = 8'h64;
      5'd14:   src_vector = 8'h68;
      5'd15:   src_vector = 8'h69;
      5'd16:   src_vector = 8'h6c;
      5'd17:   src_vector = 8'h84;
      5'd18:   src_vector = 8'h85;
      5'd19:   src_vector = 8'h86;
      5'd20:   src_vector = 8'h87;
      5'd21:   src_vector = 8'h8a;
      5'd22:   src_vector = 8'h90;
      5'd23:   src_vector = 8'h94;
      5'd24:   src_vector = 8'h98;
      default: src_vector = 8'h99;
    endcase
  endfunction

  // ==========================================================
  // state

  ipv_state_type st;
  ipv_state_type next_st;
  logic [5:0]    ext_pend;
  logic [25:0]   pend;
  logic [3:0]    best_lvl;
  logic [4:0]    best_idx;

  // ==========================================================
  // next state

  always_comb begin
    logic        setup;
    logic        done;
    logic [3:0]  sel;
    logic [5:0]  fell;
    logic        nmi_edge;
    logic        accept;
    logic [15:0] flags_rd;
    logic        clr_ack;
    logic        clr_sw;
    logic [7:0]  vec;
    logic [3:0]  eff_mask;
    setup    = APB_REQ.psel & ~APB_REQ.penable;
    done     = APB_REQ.psel & APB_REQ.penable & st.rsp.pready;
    sel      = reg_sel(APB_REQ.paddr);
    // R24 fall seen as previous sample high, current sample low
    fell     = st.ext_prev & ~st.ext_s2;
    nmi_edge = st.nonmask_edge_select ? (st.nmi_s2 & ~st.nmi_prev) : (~st.nmi_s2 & st.nmi_prev);
    accept   = INT_ACK & st.cpu.req;
    flags_rd = 16'h0000;
    clr_ack  = 1'b0;
    clr_sw   = 1'b0;
    vec      = 8'h00;
    // the cpu takes a loaded mask one cycle late: use it meanwhile
    eff_mask = st.cpu.mask_load ? st.cpu.new_mask : CPU_MASK;
    next_st  = st;

    // R1 R3 R22 low level or latched fall per pin sense bit
    for (int i = 0; i < 6; i++) begin
      ext_pend[i] = st.sense[pin_bit(i)] ? st.edge_flag[i] : ~st.ext_s2[i];
      // R4 R6 flags read back the live request
      flags_rd[pin_bit(i)] = ext_pend[i];
    end
    pend = {PERIPH_REQ, ext_pend};

    // R19 ties: strict compare keeps the lower vector
    // R20 level 0 never beats the initial zero
    best_lvl = 4'h0;
    best_idx = 5'd0;
    for (int i = 0; i < 26; i++) begin
      if (pend[i] && (src_prio(st.prio, 5'(i)) > best_lvl)) begin
        best_lvl = src_prio(st.prio, 5'(i));
        best_idx = 5'(i);
      end
    end

    // synchronisers: first stage read by the second only
    next_st.ext_s1   = EXT_REQ_PIN;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.nmi_s1   = NMI_PIN;
    next_st.nmi_s2   = st.nmi_s1;
    next_st.nmi_prev = st.nmi_s2;

    // zero-wait slave: pready in the first access cycle
    next_st.rsp.pready  = setup;
    next_st.rsp.pslverr = setup & (sel == 4'hf);
    if (setup && !APB_REQ.pwrite) begin
      case (sel)
        4'h8:    next_st.rsp.prdata = {16'h0000, st.nmi_s2, 6'h00, st.nonmask_edge_select, st.sense};
        4'h9:    next_st.rsp.prdata = {16'h0000, flags_rd};
        4'hf:    next_st.rsp.prdata = 32'h0000_0000;
        default: next_st.rsp.prdata = {16'h0000, st.prio[sel[2:0]]};
      endcase
    end

    if (done && APB_REQ.pwrite) begin
      // R2 R10 R17 four-bit fields, reserved bits kept at zero
      if (sel[3] == 1'b0) begin
        next_st.prio[sel[2:0]] = APB_REQ.pwdata[15:0] & prio_wmask(sel[2:0]);
      end
      if (sel == 4'h8) begin
        next_st.nonmask_edge_select  = APB_REQ.pwdata[`IPV_NMI_EDGE_BIT];
        next_st.sense = APB_REQ.pwdata[7:0] & `IPV_WMASK_SENSE;
      end
    end

    for (int i = 0; i < 6; i++) begin
      clr_ack = accept & ~st.win_nmi & (st.win_idx == 5'(i));
      // R7 writing 0 clears only after the flag was read as 1
      clr_sw  = done & APB_REQ.pwrite & (sel == 4'h9) &
                ~APB_REQ.pwdata[pin_bit(i)] & st.armed[i];
      // R5 R6 latch until accepted; a new fall wins over any clear
      if (st.sense[pin_bit(i)]) begin
        next_st.edge_flag[i] = fell[i] | (st.edge_flag[i] & ~clr_ack & ~clr_sw);
      end else begin
        next_st.edge_flag[i] = 1'b0;
      end
      if (done && (sel == 4'h9)) begin
        next_st.armed[i] = ~APB_REQ.pwrite & flags_rd[pin_bit(i)];
      end
    end

    // R21 nmi latched on the chosen edge, never masked
    next_st.nmi_pend = nmi_edge | (st.nmi_pend & ~(accept & st.win_nmi));

    if (accept) begin
      // R8 R11 R21 mask takes the accepted level, 15 for nmi
      next_st.cpu.mask_load = 1'b1;
      next_st.cpu.new_mask  = st.cpu.level;
      next_st.cpu.req       = 1'b0;
    end else begin
      next_st.cpu.mask_load = 1'b0;
      // R23 only above the current mask, nmi excepted
      next_st.cpu.req       = st.nmi_pend | (best_lvl > eff_mask);
      next_st.win_nmi       = st.nmi_pend;
      next_st.win_idx       = best_idx;
      // R9 R12 R14 winner picks its own vector
      vec                   = st.nmi_pend ? `IPV_NMI_VECTOR : src_vector(best_idx);
      next_st.cpu.vector    = vec;
      next_st.cpu.level     = st.nmi_pend ? `IPV_NMI_MASK : best_lvl;
      // R13 table entry is four bytes per vector
      next_st.cpu.vec_offset = {vec, 2'b00};
    end
  end

  // ==========================================================
  // registers

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      // R18 all priorities start at level 0
      st.prio      <= {8{`IPV_PRIO_RESET}};
      st.sense     <= `IPV_SENSE_RESET;
      st.nonmask_edge_select      <= 1'b0;
      // idle pins are high; avoids a false fall after reset
      st.ext_s1    <= 6'h3f;
      st.ext_s2    <= 6'h3f;
      st.ext_prev  <= 6'h3f;
      st.edge_flag <= 6'h00;
      st.armed     <= 6'h00;
      st.nmi_s1    <= 1'b1;
      st.nmi_s2    <= 1'b1;
      st.nmi_prev  <= 1'b1;
      st.nmi_pend  <= 1'b0;
      st.win_nmi   <= 1'b0;
      st.win_idx   <= 5'd0;
      st.rsp       <= '0;
      st.cpu       <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign APB_RSP = st.rsp;
  assign CPU_INT = st.cpu;

  // ==========================================================
  // checks

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  sequence s_pin0_fall_edge;
    st.sense[7] && st.ext_prev[0] && !st.ext_s2[0];
  endsequence

  sequence s_accept;
    INT_ACK && st.cpu.req;
  endsequence

  a_edge_latch_pin0: assert property (s_pin0_fall_edge |=> st.edge_flag[0]) // R5
    else $error("falling edge on pin 0 not latched");

  a_edge_hold_pin0: assert property ( // R6
    st.sense[7] && st.edge_flag[0] && !INT_ACK && !(APB_REQ.psel && APB_REQ.pwrite)
    |=> st.edge_flag[0])
    else $error("latched pin 0 request lost without accept or clear");

  a_noarm_keep: assert property ( // R7
    st.sense[7] && st.edge_flag[0] && !st.armed[0] && !INT_ACK
    |=> st.edge_flag[0])
    else $error("flag cleared without a prior read of 1");

  // set wins: an accept of pin 0 with no new fall drops the flag
  a_ack_clear_pin0: assert property ( // R6
    INT_ACK && st.cpu.req && !st.win_nmi && st.win_idx == 5'd0 && st.sense[7]
    && !(st.ext_prev[0] && !st.ext_s2[0]) |=> !st.edge_flag[0])
    else $error("accepted pin 0 request still latched");

  // pin seen two edges later, once both sync stages are out of reset
  a_level_follow: assert property ( // R3
    !st.sense[7] && !st.sense[6] && !$past(SRST) && !$past(SRST, 2)
    |-> ext_pend[1:0] == ~$past(EXT_REQ_PIN[1:0], 2))
    else $error("level request does not follow the pin");

  a_accept_mask: assert property ( // R8 R11
    s_accept |=> CPU_INT.mask_load && CPU_INT.new_mask == $past(st.cpu.level)
    ##1 !CPU_INT.mask_load)
    else $error("mask not loaded with the accepted level");

  a_nmi_mask: assert property ( // R21
    s_accept and st.win_nmi |=> CPU_INT.new_mask == 4'hf)
    else $error("nmi accept did not load mask 15");

  a_nmi_vector: assert property ( // R14
    CPU_INT.req && st.win_nmi |-> CPU_INT.vector == 8'h0b)
    else $error("nmi presented with a wrong vector");

  a_mask_gate: assert property ( // R23
    CPU_INT.req && !st.win_nmi |-> CPU_INT.level > $past(CPU_MASK)
    && CPU_INT.level != 4'h0)
    else $error("request presented at or below the cpu mask");

  a_vec_offset: assert property ( // R13
    CPU_INT.req |-> CPU_INT.vec_offset == {CPU_INT.vector, 2'b00})
    else $error("vector offset is not four times the vector");

  a_prio_reset: assert property ( // R18
    @(posedge REF_CLK) disable iff (1'b0) SRST |=> st.prio == '0)
    else $error("priorities not cleared by reset");

endmodule

// >>> tb/ipv_cpu_model.sv
// cpu core model: accepts presented interrupts and keeps the status mask
`timescale 1ns/10ps

module ipv_cpu_model (
  input  wire logic                     REF_CLK,
  input  wire logic                     SRST,
  input  wire ipv_pkg::ipv_cpu_int_type CPU_INT,
  input  wire logic                     ACK_EN,
  input  wire logic [1:0]               ACK_DELAY,
  input  wire logic                     RET,
  output      logic                     INT_ACK,
  output      logic [3:0]               CPU_MASK
);
  import ipv_pkg::*;
  logic [1:0] wait_cnt;

  // ==========
  // acceptance
  // a busy core answers late; one pulse per presented request
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      INT_ACK <= 1'b0;
      wait_cnt <= 2'h0;
      CPU_MASK <= 4'h0;
    end else begin
      INT_ACK <= 1'b0;
      if (CPU_INT.req && ACK_EN && !INT_ACK) begin
        if (wait_cnt == ACK_DELAY) begin
          INT_ACK <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end else begin
        wait_cnt <= 2'h0;
      end
      // mask follows the load; return from handler drops it to 0
      if (CPU_INT.mask_load) begin
        CPU_MASK <= CPU_INT.new_mask;
      end else if (RET) begin
        CPU_MASK <= 4'h0;
      end
    end
  end
endmodule

// >>> tb/test_irq_detect_priority_vector.sv
// self-checking bench of the interrupt arbiter with a cpu model beside it
`timescale 1ns/10ps
`include "ipv_regs.svh"

module test_irq_detect_priority_vector;
  import ipv_pkg::*;
  typedef struct packed {
    logic        kind;
    logic [35:0] val;
  } ipv_exp_type;
  logic            ref_clk;
  logic            srst;
  ipv_apb_req_type apb_req;
  ipv_apb_rsp_type apb_rsp;
  logic [5:0]      ext_pin;
  logic            nmi_pin;
  logic [19:0]     periph;
  logic [3:0]      cpu_mask;
  logic            int_ack;
  ipv_cpu_int_type cpu_int;
  logic            ack_en;
  logic [1:0]      ack_delay;
  logic            ret;
  logic            mask_chk = 1'b0;
  logic [3:0]      mask_exp = 4'h0;
  int              failures;
  int              num_checks;
  ipv_exp_type     exp_q[$];
  ipv_exp_type     ent;
  logic [7:0]      vecs[20] = '{88, 89, 90, 91, 92, 96, 97, 100, 104, 105, 108,
                                132, 133, 134, 135, 138, 144, 148, 152, 153};
  logic [3:0]      levs[20] = '{9, 9, 9, 9, 10, 11, 11, 12, 13, 13, 14,
                                7, 7, 7, 7, 6, 5, 4, 8, 8};
  logic [15:0]     wmask[8] = '{`IPV_WMASK_PRIO_A, `IPV_WMASK_PRIO_B, `IPV_WMASK_PRIO_C,
                                `IPV_WMASK_PRIO_D, `IPV_WMASK_PRIO_E, `IPV_WMASK_PRIO_F,
                                `IPV_WMASK_PRIO_G, `IPV_WMASK_PRIO_H};
  int              ord[9] = '{0, 4, 7, 18, 19, 11, 12, 13, 14};

  ipv_int_arbiter u_dut (
    .REF_CLK     (ref_clk),
    .SRST        (srst),
    .APB_REQ     (apb_req),
    .APB_RSP     (apb_rsp),
    .EXT_REQ_PIN (ext_pin),
    .NMI_PIN     (nmi_pin),
    .PERIPH_REQ  (periph),
    .CPU_MASK    (cpu_mask),
    .INT_ACK     (int_ack),
    .CPU_INT     (cpu_int)
  );

  ipv_cpu_model u_cpu (
    .REF_CLK   (ref_clk),
    .SRST      (srst),
    .CPU_INT   (cpu_int),
    .ACK_EN    (ack_en),
    .ACK_DELAY (ack_delay),
    .RET       (ret),
    .INT_ACK   (int_ack),
    .CPU_MASK  (cpu_mask)
  );

  // ==========
  // compare and report
  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic take(input logic kind, input logic [35:0] got);
    if (exp_q.size() == 0 || exp_q[0].kind !== kind) begin
      num_checks++;
      failures++;
      $display("[ERR] %s expected none seen %h", kind ? "accept" : "read", got);
    end else begin
      ent = exp_q.pop_front();
      chk(kind ? "accept" : "read", ent.val, got);
    end
  endtask

  task automatic test_done();
    if (exp_q.size() != 0) failures++;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========
  // monitor: results are matched against the oldest note
  always @(posedge ref_clk) begin
    mask_chk <= 1'b0;
    if (mask_chk) begin
      chk("mask load", 36'({2'b10, mask_exp}),
          36'({cpu_int.mask_load, cpu_int.req, cpu_int.new_mask}));
    end
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
      take(1'b0, 36'({apb_rsp.pslverr, apb_rsp.prdata}));
    end
    if (int_ack && cpu_int.req === 1'b1) begin
      take(1'b1, 36'({cpu_int.level, cpu_int.vector, cpu_int.vec_offset}));
      mask_chk <= 1'b1;
      mask_exp <= ent.val[21:18];
    end
  end

  // ==========
  // drivers
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
                     input logic [31:0] e, input logic err);
    if (!wr) exp_q.push_back('{1'b0, 36'({err, e})});
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= {idx[29:0], 2'b00};
    apb_req.pwdata <= wd;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // expect one acceptance, then retire the source and return
  task automatic serve(input logic [7:0] vec, input logic [3:0] lev,
                       input logic [19:0] pdrop, input logic [5:0] prel);
    exp_q.push_back('{1'b1, 36'({lev, vec, vec, 2'b00})});
    ack_delay <= 2'($urandom_range(3));
    ack_en <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (cpu_int.mask_load !== 1'b1);
    repeat (6) @(posedge ref_clk);
    periph <= periph & ~pdrop;
    ext_pin <= ext_pin | prel;
    repeat (6) @(posedge ref_clk);
    ack_en <= 1'b0;
    ret <= 1'b1;
    @(posedge ref_clk);
    ret <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic quiet(input int n);
    ack_en <= 1'b1;
    repeat (n) begin
      @(posedge ref_clk);
      chk("idle req", 36'h0, 36'(cpu_int.req));
    end
    ack_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ==========
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done();
  end

  // ==========
  // tests
  initial begin
    int i;
    logic [31:0] d;
    srst = 1'b1;
    apb_req = '0;
    ext_pin = 6'h3f;
    nmi_pin = 1'b1;
    periph = 20'h0;
    ack_en = 1'b0;
    ack_delay = 2'h0;
    ret = 1'b0;
    failures = 0;
    num_checks = 0;
    void'($urandom(71709));
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 11; i++) begin
      apb(0, 32'(`IPV_IDX_PRIO_A + 2 * i), 0, (i == 8) ? 32'h8000 : 32'h0, i == 10);
    end
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      apb(1, 32'(`IPV_IDX_PRIO_A + 2 * i), d, 0, 0);
      apb(0, 32'(`IPV_IDX_PRIO_A + 2 * i), 0, {16'h0, d[15:0] & wmask[i]}, 0);
    end
    $display("priority field test done");
    apb(1, `IPV_IDX_SENSE_CTRL, 32'h0080, 0, 0);
    apb(1, `IPV_IDX_PRIO_A, 32'h5000, 0, 0);
    apb(1, `IPV_IDX_PRIO_B, 32'h0003, 0, 0);
    ext_pin[0] <= 1'b0;
    repeat (5) @(posedge ref_clk);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0080, 0);
    apb(1, `IPV_IDX_REQ_FLAGS, 32'h00ff, 0, 0);
    apb(1, `IPV_IDX_REQ_FLAGS, 32'h0000, 0, 0);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0080, 0);
    apb(1, `IPV_IDX_REQ_FLAGS, 32'h0000, 0, 0);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0000, 0);
    ext_pin[0] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ext_pin[0] <= 1'b0;
    serve(8'd64, 4'h5, 20'h0, 6'h01);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0000, 0);
    $display("edge pin test done");
    ext_pin[5] <= 1'b0;
    repeat (5) @(posedge ref_clk);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0001, 0);
    serve(8'd71, 4'h3, 20'h0, 6'h20);
    apb(0, `IPV_IDX_REQ_FLAGS, 0, 32'h0000, 0);
    ext_pin[1] <= 1'b0;
    quiet(20);
    ext_pin[1] <= 1'b1;
    $display("level pin test done");
    apb(1, `IPV_IDX_PRIO_D, 32'h9abc, 0, 0);
    apb(1, `IPV_IDX_PRIO_E, 32'hde00, 0, 0);
    apb(1, `IPV_IDX_PRIO_F, 32'h0007, 0, 0);
    apb(1, `IPV_IDX_PRIO_G, 32'h6054, 0, 0);
    apb(1, `IPV_IDX_PRIO_H, 32'h8000, 0, 0);
    for (i = 0; i < 20; i++) begin
      periph[i] <= 1'b1;
      serve(vecs[i], levs[i], 20'h1 << i, 6'h0);
    end
    $display("peripheral vector test done");
    apb(1, `IPV_IDX_PRIO_D, 32'h9999, 0, 0);
    periph <= 20'hc7891;
    for (i = 0; i < 9; i++) begin
      serve(vecs[ord[i]], (i < 3) ? 4'h9 : levs[ord[i]], 20'h1 << ord[i], 6'h0);
    end
    $display("ranking test done");
    nmi_pin <= 1'b0;
    serve(8'd11, 4'hf, 20'h0, 6'h0);
    apb(1, `IPV_IDX_SENSE_CTRL, 32'h0180, 0, 0);
    apb(0, `IPV_IDX_SENSE_CTRL, 0, 32'h0180, 0);
    nmi_pin <= 1'b1;
    serve(8'd11, 4'hf, 20'h0, 6'h0);
    apb(0, `IPV_IDX_SENSE_CTRL, 0, 32'h8180, 0);
    nmi_pin <= 1'b0;
    quiet(10);
    $display("nonmaskable test done");
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule
